// *** pkg/afm_regs.vh ***
/*
 * afm_regs.vh: object indices, field positions, reset values and timing counts
 * for the amplifier fault manager.
 * assumes: included by bare name from design files under src/.
 */
`ifndef AFM_REGS_VH
`define AFM_REGS_VH

// object indices and sub-indices
`define AFM_IDX_ERR_SUMMARY     16'h1001
`define AFM_IDX_MFR_STATUS      16'h1002
`define AFM_IDX_ERR_HISTORY     16'h1003
`define AFM_IDX_TRACK_WINDOW    16'h2120
`define AFM_IDX_FAULT_SELECT    16'h2182
`define AFM_IDX_FAULT_LATCH     16'h2183
`define AFM_SUB_HIST_COUNT      8'h00
`define AFM_HIST_DEPTH          4'h8

// error summary bit positions
`define AFM_SUM_GENERIC         0
`define AFM_SUM_CURRENT         1
`define AFM_SUM_VOLTAGE         2
`define AFM_SUM_TEMP            3
`define AFM_SUM_COMM            4
`define AFM_SUM_MOTION          7

// fault select / latch bit positions
`define AFM_F_FLASH_CRC         0
`define AFM_F_SELF_TEST         1
`define AFM_F_SHORT             2
`define AFM_F_AMP_TEMP          3
`define AFM_F_MOTOR_TEMP        4
`define AFM_F_OVER_V            5
`define AFM_F_UNDER_V           6
`define AFM_F_FEEDBACK          7
`define AFM_F_PHASING           8
`define AFM_F_TRACKING          9
`define AFM_F_CUR_HEAT          10
`define AFM_F_LOGIC             11
`define AFM_F_CMD_LOST          12

// writable fault select bits, fixed read-only bits
`define AFM_SEL_WR_MASK         32'h000017FC
`define AFM_SEL_RO_MASK         32'h00000803
`define AFM_SEL_RESET           32'h00000000
`define AFM_WINDOW_RESET        32'h00000000

// manufacturer status word bit positions
`define AFM_MFR_TRACK_WARN      18
`define AFM_MFR_FAULT           22

// timing
`define AFM_CLK_KHZ             125000
`define AFM_SHORT_OFF_MS        100

`endif

// *** src/afm_sync.v ***
/*
 * afm_sync.v: three-stage input synchroniser per bit; the output follows a
 * change once the second and third stages agree.
 * assumes: inputs are asynchronous pins, single clock clk_in.
 */
module afm_sync #(
    parameter W = 1
) (
    input  wire         clk_in,
    input  wire         reset_n_in,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1;
            reg s2;
            reg s3;
            reg stable;
            always @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    s1     <= 1'b0;
                    s2     <= 1'b0;
                    s3     <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    s1 <= async_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        stable <= s3;
                    end
                end
            end
            assign sync_out[i] = stable;
        end
    endgenerate
endmodule // afm_sync

// *** src/afm_fault_manager.v ***
/*
 * afm_fault_manager.v: error history, error summary, tracking window
 * comparator, fault select mask and latched fault status with recovery timing.
 * assumes: object access port driven by same-clock host logic, one request
 * at a time; condition inputs are asynchronous pins; position error and error
 * push come from same-clock logic.
 */
// Functional notes
// - keep eight history words: code in low half, extra info in high half
// - new error enters slot one, older slots shift down, count kept apart
// - writing count zero empties history; nonzero count write answers error
// - summary bit 0 set whenever any error condition is present
// - summary bit 1 for output short or encoder overcurrent
// - summary bit 2 for bus voltage over or under limits
// - summary bit 3 amp over-temp, or motor over-temp when input configured
// - summary bit 4 unused reads zero; bits 5 and 6 reserved
// - summary bit 7 for phasing error, tracking error or limit switch
// - position error beyond window raises tracking event and status bit 18
// - select bit one latches its event as fault; zero disables latching
// - select bits 0,1,11 read-only startup failures; keep amplifier disabled
// - short latches if bit 2 set; else outputs off 100 ms, then on
// - bits 3,4 latch temperatures; else re-enable when condition clears
// - bits 5 and 6 latch over and under bus voltage
// - bit 7 latches feedback faults: encoder overcurrent, disconnect, levels
// - bit 8 latches phasing; else re-enable when phasing error removed
// - bit 9 latches tracking disabled; else abort move, stay enabled
// - bit 10 latches current heating limit events
// - bit 12 latches command loss; bits 13 to 31 reserved
// - writing one to a latched status bit clears that fault
`include "afm_regs.vh"

module afm_fault_manager #(
    parameter SHORT_OFF_CYCLES = `AFM_SHORT_OFF_MS * `AFM_CLK_KHZ
) (
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire [15:0] od_index_in,
    input  wire [7:0]  od_sub_in,
    input  wire        od_rd_in,
    input  wire        od_wr_in,
    input  wire [31:0] od_wdata_in,
    output reg  [31:0] od_rdata_out,
    output reg         od_ack_out,
    output reg         od_err_out,
    input  wire        err_push_in,
    input  wire [31:0] err_entry_in,
    input  wire [31:0] pos_err_in,
    input  wire        motor_temp_cfg_in,
    input  wire        short_in,
    input  wire        enc_overcurrent_in,
    input  wire        over_v_in,
    input  wire        under_v_in,
    input  wire        amp_temp_in,
    input  wire        motor_temp_in,
    input  wire        feedback_fault_in,
    input  wire        phasing_in,
    input  wire        limit_in,
    input  wire        current_heating_limit_in,
    input  wire        cmd_lost_in,
    input  wire        flash_crc_fail_in,
    input  wire        self_test_fail_in,
    input  wire        logic_fail_in,
    output reg  [7:0]  error_summary_out,
    output reg  [31:0] latched_faults_out,
    output reg         tracking_warn_out,
    output reg         fault_out,
    output reg         drive_enable_out,
    output reg         abort_move_out
);
    localparam integer SHORT_OFF_INT = SHORT_OFF_CYCLES;
    localparam [23:0]  SHORT_OFF     = SHORT_OFF_INT[23:0];

    wire [13:0] cond_sync;
    wire        s_short;
    wire        s_enc_oc;
    wire        s_over_v;
    wire        s_under_v;
    wire        s_amp_temp;
    wire        s_motor_temp;
    wire        s_feedback;
    wire        s_phasing;
    wire        s_limit;
    wire        s_cur_heat;
    wire        s_cmd_lost;
    wire        s_flash;
    wire        s_self_test;
    wire        s_logic;

    afm_sync #(
        .W(14)
    ) u_sync (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({logic_fail_in, self_test_fail_in, flash_crc_fail_in,
                      cmd_lost_in, current_heating_limit_in, limit_in, phasing_in,
                      feedback_fault_in, motor_temp_in, amp_temp_in, under_v_in,
                      over_v_in, enc_overcurrent_in, short_in}),
        .sync_out   (cond_sync)
    );

    assign s_short      = cond_sync[0];
    assign s_enc_oc     = cond_sync[1];
    assign s_over_v     = cond_sync[2];
    assign s_under_v    = cond_sync[3];
    assign s_amp_temp   = cond_sync[4];
    assign s_motor_temp = cond_sync[5] & motor_temp_cfg_in;
    assign s_feedback   = cond_sync[6];
    assign s_phasing    = cond_sync[7];
    assign s_limit      = cond_sync[8];
    assign s_cur_heat   = cond_sync[9];
    assign s_cmd_lost   = cond_sync[10];
    assign s_flash      = cond_sync[11];
    assign s_self_test  = cond_sync[12];
    assign s_logic      = cond_sync[13];

    reg  [31:0] hist [0:7];
    reg  [3:0]  hist_count;
    reg  [31:0] track_window;
    reg  [31:0] fault_select;
    reg  [23:0] short_timer;
    reg         short_seen;
    reg         track_seen;

    // tracking comparator
    wire [31:0] pos_abs   = pos_err_in[31] ? (~pos_err_in + 32'h00000001) : pos_err_in;
    wire        track_now = pos_abs > track_window;
    wire        track_evt = track_now & ~track_seen;

    // request decode
    wire        is_hist   = (od_index_in == `AFM_IDX_ERR_HISTORY);
    wire        sub_entry = (od_sub_in != 8'h00) && (od_sub_in <= {4'h0, `AFM_HIST_DEPTH});
    wire        hist_zero = od_wr_in && is_hist && (od_sub_in == `AFM_SUB_HIST_COUNT)
                            && (od_wdata_in == 32'h00000000);
    wire [2:0]  sub_slot  = od_sub_in[2:0] - 3'h1;

    // present conditions per fault bit
    reg  [31:0] cond_vec;
    always @* begin
        cond_vec = 32'h00000000;
        cond_vec[`AFM_F_FLASH_CRC]  = s_flash;
        cond_vec[`AFM_F_SELF_TEST]  = s_self_test;
        cond_vec[`AFM_F_SHORT]      = s_short;
        cond_vec[`AFM_F_AMP_TEMP]   = s_amp_temp;
        cond_vec[`AFM_F_MOTOR_TEMP] = s_motor_temp;
        cond_vec[`AFM_F_OVER_V]     = s_over_v;
        cond_vec[`AFM_F_UNDER_V]    = s_under_v;
        cond_vec[`AFM_F_FEEDBACK]   = s_enc_oc | s_feedback;
        cond_vec[`AFM_F_PHASING]    = s_phasing;
        cond_vec[`AFM_F_TRACKING]   = track_now;
        cond_vec[`AFM_F_CUR_HEAT]   = s_cur_heat;
        cond_vec[`AFM_F_LOGIC]      = s_logic;
        cond_vec[`AFM_F_CMD_LOST]   = s_cmd_lost;
    end

    // effective select: startup failures always latch
    wire [31:0] eff_select = (fault_select & `AFM_SEL_WR_MASK) | `AFM_SEL_RO_MASK;
    wire [31:0] latch_set  = cond_vec & eff_select;
    wire [31:0] ro_sel     = {20'h00000, s_logic, 9'h000, s_self_test, s_flash};

    // summary from present conditions only
    reg  [7:0]  next_summary;
    always @* begin
        next_summary = 8'h00;
        next_summary[`AFM_SUM_CURRENT] = s_short | s_enc_oc;
        next_summary[`AFM_SUM_VOLTAGE] = s_over_v | s_under_v;
        next_summary[`AFM_SUM_TEMP]    = s_amp_temp | s_motor_temp;
        next_summary[`AFM_SUM_MOTION]  = s_phasing | track_now | s_limit;
        next_summary[`AFM_SUM_GENERIC] = (|next_summary) | s_feedback | s_cur_heat
                                         | s_cmd_lost | s_flash | s_self_test
                                         | s_logic;
    end

    // non-latching outages: short timer, temperature, phasing
    wire short_new  = s_short & ~short_seen;
    wire soft_hold  = (short_timer != 24'h000000)
                      | (s_amp_temp & ~eff_select[`AFM_F_AMP_TEMP])
                      | (s_motor_temp & ~eff_select[`AFM_F_MOTOR_TEMP])
                      | (s_phasing & ~eff_select[`AFM_F_PHASING]);

    // manufacturer status word image
    wire [31:0] mfr_word = ({31'h00000000, track_now} << `AFM_MFR_TRACK_WARN)
                           | ({31'h00000000, |latched_faults_out} << `AFM_MFR_FAULT);

    // read mux
    reg  [31:0] next_rdata;
    reg         next_err;
    always @* begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        case (od_index_in)
            `AFM_IDX_ERR_SUMMARY: begin
                next_rdata = {24'h000000, error_summary_out};
                next_err   = od_wr_in;
            end
            `AFM_IDX_MFR_STATUS: begin
                next_rdata = mfr_word;
                next_err   = od_wr_in;
            end
            `AFM_IDX_ERR_HISTORY: begin
                if (od_sub_in == `AFM_SUB_HIST_COUNT) begin
                    next_rdata = {28'h0000000, hist_count};
                    next_err   = od_wr_in && (od_wdata_in != 32'h00000000);
                end else if (sub_entry) begin
                    next_rdata = hist[sub_slot];
                end else begin
                    next_err = 1'b1;
                end
            end
            `AFM_IDX_TRACK_WINDOW: begin
                next_rdata = track_window;
                next_err   = od_wr_in && od_wdata_in[31];
            end
            `AFM_IDX_FAULT_SELECT: begin
                next_rdata = (fault_select & `AFM_SEL_WR_MASK) | ro_sel;
            end
            `AFM_IDX_FAULT_LATCH: begin
                next_rdata = latched_faults_out;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // history slots shift on push
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_hist
            always @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    hist[k] <= 32'h00000000;
                end else if (err_push_in) begin
                    if (k == 0) begin
                        hist[k] <= err_entry_in;
                    end else begin
                        hist[k] <= hist_zero ? 32'h00000000 : hist[(k + 7) % 8];
                    end
                end else if (hist_zero) begin
                    hist[k] <= 32'h00000000;
                end else if (od_wr_in && is_hist && sub_entry && (sub_slot == k)) begin
                    hist[k] <= od_wdata_in;
                end
            end
        end
    endgenerate

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hist_count <= 4'h0;
        end else if (err_push_in) begin
            if (hist_zero) begin
                hist_count <= 4'h1;
            end else if (hist_count != `AFM_HIST_DEPTH) begin
                hist_count <= hist_count + 4'h1;
            end
        end else if (hist_zero) begin
            hist_count <= 4'h0;
        end
    end

    // host access, configuration and latch state
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            od_rdata_out       <= 32'h00000000;
            od_ack_out         <= 1'b0;
            od_err_out         <= 1'b0;
            track_window       <= `AFM_WINDOW_RESET;
            fault_select       <= `AFM_SEL_RESET;
            latched_faults_out <= 32'h00000000;
        end else begin
            od_ack_out   <= od_rd_in | od_wr_in;
            od_err_out   <= (od_rd_in | od_wr_in) & next_err;
            od_rdata_out <= od_rd_in ? next_rdata : 32'h00000000;
            if (od_wr_in && !next_err) begin
                if (od_index_in == `AFM_IDX_TRACK_WINDOW) begin
                    track_window <= od_wdata_in;
                end
                if (od_index_in == `AFM_IDX_FAULT_SELECT) begin
                    fault_select <= od_wdata_in & `AFM_SEL_WR_MASK;
                end
            end
            if (od_wr_in && !next_err && od_index_in == `AFM_IDX_FAULT_LATCH) begin
                latched_faults_out <= (latched_faults_out & ~od_wdata_in) | latch_set;
            end else begin
                latched_faults_out <= latched_faults_out | latch_set;
            end
        end
    end

    // status outputs, short-circuit outage, tracking response
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            error_summary_out <= 8'h00;
            tracking_warn_out <= 1'b0;
            fault_out         <= 1'b0;
            drive_enable_out  <= 1'b0;
            abort_move_out    <= 1'b0;
            short_timer       <= 24'h000000;
            short_seen        <= 1'b0;
            track_seen        <= 1'b0;
        end else begin
            error_summary_out <= next_summary;
            tracking_warn_out <= track_now;
            fault_out         <= |latched_faults_out;
            short_seen        <= s_short;
            track_seen        <= track_now;
            if (short_new && !eff_select[`AFM_F_SHORT]) begin
                short_timer <= SHORT_OFF;
            end else if (short_timer != 24'h000000) begin
                short_timer <= short_timer - 24'h000001;
            end
            abort_move_out   <= track_evt & ~eff_select[`AFM_F_TRACKING];
            drive_enable_out <= ~(|latched_faults_out) & ~(|latch_set) & ~soft_hold
                                & ~(short_new & ~eff_select[`AFM_F_SHORT])
                                & ~s_over_v & ~s_under_v;
        end
    end
endmodule // afm_fault_manager

// *** test/afm_fault_monitor.sv ***
/* afm_fault_monitor: port assertions for afm_fault_manager.
   assumes: one clock clk_in, async active-low reset_n_in, bound by name. */
module afm_fault_monitor #(
    parameter SHORT_OFF_CYCLES = 20
) (
    input wire        clk_in,
    input wire        reset_n_in,
    input wire [15:0] od_index_in,
    input wire [7:0]  od_sub_in,
    input wire        od_wr_in,
    input wire [31:0] od_wdata_in,
    input wire        od_ack_out,
    input wire        od_err_out,
    input wire        short_in,
    input wire        enc_overcurrent_in,
    input wire        over_v_in,
    input wire        under_v_in,
    input wire        flash_crc_fail_in,
    input wire [7:0]  error_summary_out,
    input wire [31:0] latched_faults_out,
    input wire        fault_out,
    input wire        drive_enable_out,
    input wire        abort_move_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    a_count_write_refused: assert property (od_wr_in && od_index_in == 16'h1003 && od_sub_in == 8'h00
        && od_wdata_in != 32'h0 |=> od_ack_out && od_err_out) else $error("count write accepted");
    a_summary_generic: assert property (error_summary_out[7:1] != 7'h00 |-> error_summary_out[0])
        else $error("generic bit missing");
    a_current_flag: assert property ((short_in || enc_overcurrent_in)[*7] |-> error_summary_out[1])
        else $error("current bit missing");
    a_voltage_flag: assert property ((over_v_in || under_v_in)[*7] |-> error_summary_out[2])
        else $error("voltage bit missing");
    a_comm_unused: assert property (error_summary_out[6:4] == 3'h0)
        else $error("unused summary bits set");
    a_current_drops: assert property ((!short_in && !enc_overcurrent_in)[*7] |-> !error_summary_out[1])
        else $error("current bit stuck");
    a_reserved_latch: assert property (latched_faults_out[31:13] == 19'h0)
        else $error("reserved latch bits set");
    a_fault_follows: assert property (fault_out == $past(|latched_faults_out))
        else $error("fault output wrong");
    a_startup_disable: assert property (flash_crc_fail_in[*7] |-> !drive_enable_out && latched_faults_out[0])
        else $error("startup failure not held");
    a_abort_pulse: assert property (abort_move_out |-> drive_enable_out ##1 !abort_move_out)
        else $error("abort pulse wrong");
endmodule // afm_fault_monitor

bind afm_fault_manager afm_fault_monitor #(.SHORT_OFF_CYCLES(SHORT_OFF_CYCLES)) u_mon (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .od_index_in(od_index_in), .od_sub_in(od_sub_in),
    .od_wr_in(od_wr_in), .od_wdata_in(od_wdata_in), .od_ack_out(od_ack_out), .od_err_out(od_err_out),
    .short_in(short_in), .enc_overcurrent_in(enc_overcurrent_in), .over_v_in(over_v_in),
    .under_v_in(under_v_in), .flash_crc_fail_in(flash_crc_fail_in),
    .error_summary_out(error_summary_out), .latched_faults_out(latched_faults_out),
    .fault_out(fault_out), .drive_enable_out(drive_enable_out), .abort_move_out(abort_move_out));

// *** test/afm_host_model.sv ***
/* afm_host_model: network host issuing object reads and writes.
   assumes: one-cycle request strobes, answer one cycle later. */
module afm_host_model (
    input wire logic         clk_in,
    output logic     [15:0]  od_index_out,
    output logic     [7:0]   od_sub_out,
    output logic             od_rd_out,
    output logic             od_wr_out,
    output logic     [31:0]  od_wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [32:0] exp_q[$];
    initial begin
        {od_index_out, od_sub_out, od_rd_out, od_wr_out, od_wdata_out} <= '0;
    end
    // one request, expected {err, rdata} noted for the watcher
    task automatic req(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd, input logic err, input logic [31:0] rd);
        @(posedge clk_in);
        od_rd_out <= !wr;
        od_wr_out <= wr;
        od_index_out <= idx;
        od_sub_out <= sub;
        od_wdata_out <= wd;
        exp_q.push_back({err, wr ? 32'h0 : rd});
        @(posedge clk_in);
        od_rd_out <= 1'b0;
        od_wr_out <= 1'b0;
        od_wdata_out <= ~wd;
    endtask
endmodule // afm_host_model

// *** test/amplifier_fault_manager_tb_top.sv ***
/* amplifier_fault_manager_tb_top: self-checking bench for afm_fault_manager.
   assumes: 125 MHz clock, short-off count cut to 20 cycles. */
`include "afm_regs.vh"
module amplifier_fault_manager_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0, reset_n_in = 1'b0, err_push = 1'b0, cfg = 1'b0;
    logic [31:0] err_entry = 32'h0, pos_err = 32'h0;
    logic [13:0] cond = 14'h0;
    logic [31:0] ent [0:8];
    wire  [15:0] od_index;
    wire  [7:0]  od_sub;
    wire         od_rd, od_wr, od_ack, od_err, warn, fault, drive, abort_mv;
    wire  [31:0] od_wdata, od_rdata, latched;
    wire  [7:0]  summary;
    int          mismatches = 0, n_compared = 0, seed = 32, aborts = 0, k;
    localparam logic [7:0]  SUM [0:10] = '{8'h03, 8'h03, 8'h05, 8'h05, 8'h09, 8'h09, 8'h01,
                                          8'h81, 8'h81, 8'h01, 8'h01};
    localparam logic [31:0] LAT [0:10] = '{32'h4, 32'h80, 32'h20, 32'h40, 32'h8, 32'h10, 32'h80,
                                          32'h100, 32'h0, 32'h400, 32'h1000};

    afm_host_model host (.clk_in(clk_in), .od_index_out(od_index), .od_sub_out(od_sub),
        .od_rd_out(od_rd), .od_wr_out(od_wr), .od_wdata_out(od_wdata));
    afm_fault_manager #(.SHORT_OFF_CYCLES(20)) uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .od_index_in(od_index), .od_sub_in(od_sub), .od_rd_in(od_rd), .od_wr_in(od_wr),
        .od_wdata_in(od_wdata), .od_rdata_out(od_rdata), .od_ack_out(od_ack), .od_err_out(od_err),
        .err_push_in(err_push), .err_entry_in(err_entry), .pos_err_in(pos_err),
        .motor_temp_cfg_in(cfg), .short_in(cond[0]), .enc_overcurrent_in(cond[1]),
        .over_v_in(cond[2]), .under_v_in(cond[3]), .amp_temp_in(cond[4]),
        .motor_temp_in(cond[5]), .feedback_fault_in(cond[6]), .phasing_in(cond[7]),
        .limit_in(cond[8]), .current_heating_limit_in(cond[9]), .cmd_lost_in(cond[10]),
        .flash_crc_fail_in(cond[11]), .self_test_fail_in(cond[12]), .logic_fail_in(cond[13]),
        .error_summary_out(summary), .latched_faults_out(latched), .tracking_warn_out(warn),
        .fault_out(fault), .drive_enable_out(drive), .abort_move_out(abort_mv));

    task check(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    initial begin
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        cyc(20000);
        check(33'h1, 33'h0);
        test_done;
    end
    // answer watcher: oldest note against each acknowledged answer
    always @(posedge clk_in) begin
        if (abort_mv === 1'b1) aborts <= aborts + 1;
        if (od_ack === 1'b1) begin
            if (host.exp_q.size() == 0) check({od_err, od_rdata}, 33'h1FFFFFFFF);
            else check({od_err, od_rdata}, host.exp_q.pop_front());
        end
    end

    initial begin
        cyc(16);
        reset_n_in <= 1'b1;
        cfg <= 1'b1;
        host.req(0, `AFM_IDX_FAULT_SELECT, 0, 0, 0, `AFM_SEL_RESET);
        host.req(0, `AFM_IDX_TRACK_WINDOW, 0, 0, 0, `AFM_WINDOW_RESET);
        host.req(0, `AFM_IDX_ERR_SUMMARY, 0, 0, 0, 32'h0);
        host.req(1, `AFM_IDX_ERR_SUMMARY, 0, 32'h1, 1, 0);
        host.req(0, 16'h2000, 0, 0, 1, 0);
        host.req(1, `AFM_IDX_FAULT_SELECT, 0, 32'hFFFFFFFF, 0, 0);
        host.req(0, `AFM_IDX_FAULT_SELECT, 0, 0, 0, `AFM_SEL_WR_MASK);
        check(drive, 1'b1);
        for (k = 0; k < 9; k++) begin
            ent[k] = $random(seed);
            @(posedge clk_in);
            err_push <= 1'b1;
            err_entry <= ent[k];
            @(posedge clk_in);
            err_push <= 1'b0;
        end
        host.req(0, `AFM_IDX_ERR_HISTORY, 0, 0, 0, 32'h8);
        for (k = 1; k <= 8; k++) host.req(0, `AFM_IDX_ERR_HISTORY, k, 0, 0, ent[9-k]);
        host.req(0, `AFM_IDX_ERR_HISTORY, 9, 0, 1, 0);
        host.req(1, `AFM_IDX_ERR_HISTORY, 0, 32'h5, 1, 0);
        host.req(0, `AFM_IDX_ERR_HISTORY, 1, 0, 0, ent[8]);
        host.req(1, `AFM_IDX_ERR_HISTORY, 2, ent[0], 0, 0);
        host.req(0, `AFM_IDX_ERR_HISTORY, 2, 0, 0, ent[0]);
        host.req(1, `AFM_IDX_ERR_HISTORY, 0, 32'h0, 0, 0);
        host.req(0, `AFM_IDX_ERR_HISTORY, 0, 0, 0, 32'h0);
        host.req(1, `AFM_IDX_FAULT_SELECT, 0, 32'h0, 0, 0);
        for (k = 0; k < 11; k++) begin
            cond <= 14'h1 << k;
            cyc(8);
            check(summary, SUM[k]);
            check(latched, 32'h0);
            cond <= 14'h0;
            cyc(8);
            check(summary, 8'h00);
            if (k == 0) check(drive, 1'b0);
            if (k == 0) cyc(16);
            if (k == 0) check(drive, 1'b1);
        end
        cfg <= 1'b0;
        cond <= 14'h20;
        cyc(8);
        check(summary, 8'h00);
        cond <= 14'h0;
        cyc(8);
        cfg <= 1'b1;
        host.req(1, `AFM_IDX_FAULT_SELECT, 0, 32'hFFFFFFFF, 0, 0);
        for (k = 0; k < 11; k++) begin
            cond <= 14'h1 << k;
            cyc(8);
            check(latched, LAT[k]);
            if (LAT[k] != 0) check({fault, drive}, 2'b10);
            cond <= 14'h0;
            cyc(8);
            check(latched, LAT[k]);
            host.req(1, `AFM_IDX_FAULT_LATCH, 0, LAT[k], 0, 0);
            cyc(2);
            check(latched, 32'h0);
        end
        host.req(1, `AFM_IDX_TRACK_WINDOW, 0, 32'h80000000, 1, 0);
        host.req(1, `AFM_IDX_TRACK_WINDOW, 0, 32'd100, 0, 0);
        host.req(0, `AFM_IDX_TRACK_WINDOW, 0, 0, 0, 32'd100);
        pos_err <= 32'd100;
        cyc(3);
        check(warn, 1'b0);
        pos_err <= -32'sd101;
        cyc(3);
        check({warn, latched[9], drive}, 3'b110);
        host.req(0, `AFM_IDX_MFR_STATUS, 0, 0, 0, 32'h00440000);
        pos_err <= 32'd0;
        host.req(1, `AFM_IDX_FAULT_LATCH, 0, 32'h200, 0, 0);
        host.req(1, `AFM_IDX_FAULT_SELECT, 0, 32'h0, 0, 0);
        cyc(8);
        aborts <= 0;
        pos_err <= 32'd101;
        cyc(4);
        check({warn, latched[9], drive}, 3'b101);
        check(aborts, 1);
        pos_err <= 32'd0;
        cond <= 14'h800;
        cyc(8);
        check({latched[0], drive}, 2'b10);
        host.req(0, `AFM_IDX_FAULT_SELECT, 0, 0, 0, 32'h1);
        for (k = 0; k < 50 && host.exp_q.size() > 0; k++) cyc(1);
        check(host.exp_q.size(), 0);
        test_done;
    end
endmodule // amplifier_fault_manager_tb_top
